// >>> verilog/hbm_break_matcher.v
// Hardware break matcher for break channel one
`include "hbm_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module hbm_break_matcher #(
    parameter AW = 32,
    parameter DW = 32,
    parameter XYW = 16,
    parameter CW = 12
) (
    // Clock, reset, enable
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    // Register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Main core bus
    input wire bus_valid,
    input wire [AW-1:0] bus_addr,
    input wire [DW-1:0] bus_data,
    input wire [1:0] bus_size,
    input wire bus_write,
    input wire bus_fetch,
    input wire bus_dma,
    // Fetched instruction completes execution
    input wire insn_exec_done,
    // X and Y buses
    input wire x_valid,
    input wire [XYW-1:0] x_addr,
    input wire [XYW-1:0] x_data,
    input wire x_write,
    input wire y_valid,
    input wire [XYW-1:0] y_addr,
    input wire [XYW-1:0] y_data,
    input wire y_write,
    // Channel two condition, for sequential mode
    input wire ch2_hit,
    // Break outputs
    output reg break_req,
    output reg break_before
);
    // Configuration registers
    reg [`HBM_CTL_WIDTH-1:0] ctrl_reg;
    reg [AW-1:0] addr_cmp_reg;
    reg [AW-1:0] addr_mask_reg;
    reg [XYW-1:0] xy_cmp_reg;
    reg [XYW-1:0] xy_mask_reg;
    reg [DW-1:0] data_cmp_reg;
    reg [DW-1:0] data_mask_reg;
    reg [CW-1:0] count_cfg_reg;
    // State
    reg [CW-1:0] occur_reg;
    reg [CW-1:0] occur_next;
    reg refused_reg;
    reg pend_after_reg;
    reg hit_sticky_reg;

    // Control fields
    wire [2:0] asel = ctrl_reg[`HBM_CTL_ASEL_HI:`HBM_CTL_ASEL_LO];
    wire [5:0] dsel = ctrl_reg[`HBM_CTL_DSEL_HI:`HBM_CTL_DSEL_LO];
    wire [1:0] dir = ctrl_reg[`HBM_CTL_DIR_HI:`HBM_CTL_DIR_LO];
    wire [1:0] ctyp = ctrl_reg[`HBM_CTL_CTYP_HI:`HBM_CTL_CTYP_LO];
    wire enable = ctrl_reg[`HBM_CTL_ENABLE];
    wire seq_mode = ctrl_reg[`HBM_CTL_SEQ];
    wire fetch_mode = (asel == `HBM_ASEL_FETCH);
    wire use_xy_addr = (asel == `HBM_ASEL_X) || (asel == `HBM_ASEL_Y);
    wire use_xy_data = dsel[`HBM_DSEL_X] | dsel[`HBM_DSEL_Y];
    // Y bus when either address or data select names it
    wire xy_use_y = (asel == `HBM_ASEL_Y) || dsel[`HBM_DSEL_Y];
    wire xy_valid_sel = xy_use_y ? y_valid : x_valid;
    wire xy_write_sel = xy_use_y ? y_write : x_write;
    wire [XYW-1:0] xy_addr_sel = xy_use_y ? y_addr : x_addr;
    wire [XYW-1:0] xy_data_sel = xy_use_y ? y_data : x_data;

    // More than one data condition selected
    wire [5:0] dsel_low = reg_wdata[`HBM_CTL_DSEL_HI:`HBM_CTL_DSEL_LO];
    wire dsel_multi = |(dsel_low & (dsel_low - 6'h01));

    // Masked compares
    wire addr_eq;
    wire xy_addr_eq;
    wire data_word_eq;
    wire xy_data_eq;
    reg [DW-1:0] lane_data;
    reg [DW-1:0] lane_cmp;
    reg [DW-1:0] lane_mask;

    // One comparator each for main bus address and data, one each for the shared X or Y address and data
    hbm_masked_cmp #(.WIDTH(AW)) u_addr_cmp (
        .value(bus_addr),
        .compare(addr_cmp_reg),
        .mask(addr_mask_reg),
        .match(addr_eq)
    );
    hbm_masked_cmp #(.WIDTH(XYW)) u_xy_addr_cmp (
        .value(xy_addr_sel),
        .compare(xy_cmp_reg),
        .mask(xy_mask_reg),
        .match(xy_addr_eq)
    );
    hbm_masked_cmp #(.WIDTH(DW)) u_data_cmp (
        .value(lane_data),
        .compare(lane_cmp),
        .mask(lane_mask),
        .match(data_word_eq)
    );
    hbm_masked_cmp #(.WIDTH(XYW)) u_xy_data_cmp (
        .value(xy_data_sel),
        .compare(data_cmp_reg[XYW-1:0]),
        .mask(data_mask_reg[XYW-1:0]),
        .match(xy_data_eq)
    );

    // Lane select by low address bits, big-endian 32-bit bus
    always @* begin
        lane_data = bus_data;
        lane_cmp = data_cmp_reg;
        lane_mask = data_mask_reg;
        // Other lanes are masked out
        if (dsel[`HBM_DSEL_BYTE]) begin
            lane_cmp = {4{data_cmp_reg[7:0]}};
            case (bus_addr[1:0])
                2'h0: lane_mask = {8'h00, 24'hffffff} | {data_mask_reg[7:0], 24'h000000};
                2'h1: lane_mask = {8'hff, 8'h00, 16'hffff} | {8'h00, data_mask_reg[7:0], 16'h0000};
                2'h2: lane_mask = {16'hffff, 8'h00, 8'hff} | {16'h0000, data_mask_reg[7:0], 8'h00};
                default: lane_mask = {24'hffffff, 8'h00} | {24'h000000, data_mask_reg[7:0]};
            endcase
        end else if (dsel[`HBM_DSEL_WORD]) begin
            lane_cmp = {2{data_cmp_reg[15:0]}};
            if (bus_addr[1]) begin
                lane_mask = {16'hffff, data_mask_reg[15:0]};
            end else begin
                lane_mask = {data_mask_reg[15:0], 16'hffff};
            end
        end
    end

    // Qualifier terms for the main bus
    reg main_hit;
    reg xy_hit;
    reg size_ok;
    reg dir_ok;
    reg ctyp_ok;
    always @* begin
        // Size, direction and cycle type
        size_ok = 1'b1;
        if (dsel[`HBM_DSEL_BYTE]) size_ok = (bus_size == `HBM_SIZE_BYTE);
        if (dsel[`HBM_DSEL_WORD]) size_ok = (bus_size == `HBM_SIZE_WORD);
        if (dsel[`HBM_DSEL_LONG]) size_ok = (bus_size == `HBM_SIZE_LONG);
        dir_ok = (dir == `HBM_DIR_ANY) ||
                 ((dir == `HBM_DIR_READ) && !bus_write) ||
                 ((dir == `HBM_DIR_WRITE) && bus_write);
        case (ctyp)
            `HBM_CTYP_EXEC: ctyp_ok = !bus_dma && !bus_fetch;
            `HBM_CTYP_DMA: ctyp_ok = bus_dma;
            default: ctyp_ok = 1'b1;
        endcase
        // Main bus occurrence
        if (fetch_mode) begin
            // Only the fetch address counts here
            main_hit = bus_valid && bus_fetch && addr_eq;
        end else begin
            main_hit = bus_valid && !use_xy_addr && !use_xy_data && dir_ok && ctyp_ok &&
                       ((asel != `HBM_ASEL_GEN) || addr_eq) &&
                       (!(|dsel[2:0]) || (size_ok && data_word_eq && !bus_fetch));
        end
        // X or Y bus occurrence, word-wide address and data
        xy_hit = (use_xy_addr || use_xy_data) && !fetch_mode && xy_valid_sel &&
                 (!use_xy_addr || xy_addr_eq) &&
                 (!use_xy_data || xy_data_eq) &&
                 ((dir == `HBM_DIR_ANY) ||
                  ((dir == `HBM_DIR_READ) && !xy_write_sel) ||
                  ((dir == `HBM_DIR_WRITE) && xy_write_sel));
    end

    // Sequential mode gate
    wire seq_armed;
    wire occurrence = enable && !refused_reg && (main_hit || xy_hit) && (!seq_mode || seq_armed);
    wire cfg_write = reg_wr && (reg_addr <= `HBM_ADDR_COUNT);
    wire reached = occurrence && (occur_reg + 12'h001 >= count_cfg_reg);
    wire before_opt = ctrl_reg[`HBM_CTL_BEFORE];

    // Arms on channel two, clears on break or configuration register write
    hbm_seq_tracker u_seq (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .clear(break_req || cfg_write),
        .ch2_hit(ch2_hit && enable && seq_mode),
        .armed_reg(seq_armed)
    );

    // Occurrence counter next value
    always @* begin
        occur_next = occur_reg;
        if (cfg_write || break_req) begin
            occur_next = {CW{1'b0}};
        end else if (reached) begin
            occur_next = {CW{1'b0}};
        end else if (occurrence) begin
            occur_next = occur_reg + 12'h001;
        end
    end

    // Registers, counter and break generation
    always @(posedge sys_clk) begin
        if (rst) begin
            // Reset values
            ctrl_reg <= `HBM_CTRL_RESET;
            addr_cmp_reg <= {AW{1'b0}};
            addr_mask_reg <= {AW{1'b0}};
            xy_cmp_reg <= {XYW{1'b0}};
            xy_mask_reg <= {XYW{1'b0}};
            data_cmp_reg <= {DW{1'b0}};
            data_mask_reg <= {DW{1'b0}};
            count_cfg_reg <= `HBM_COUNT_RESET;
            occur_reg <= {CW{1'b0}};
            refused_reg <= 1'b0;
            pend_after_reg <= 1'b0;
            hit_sticky_reg <= 1'b0;
            break_req <= 1'b0;
            break_before <= 1'b0;
        end else if (clk_en) begin
            // Counter step; break pulses end
            occur_reg <= occur_next;
            break_req <= 1'b0;
            break_before <= 1'b0;
            // Software writes
            if (reg_wr) begin
                case (reg_addr)
                    `HBM_ADDR_CTRL: begin
                        if (dsel_multi) begin
                            refused_reg <= 1'b1;
                        end else begin
                            ctrl_reg <= reg_wdata[`HBM_CTL_WIDTH-1:0];
                            refused_reg <= 1'b0;
                        end
                    end
                    `HBM_ADDR_ADDR_CMP: addr_cmp_reg <= reg_wdata[AW-1:0];
                    `HBM_ADDR_ADDR_MASK: addr_mask_reg <= reg_wdata[AW-1:0];
                    `HBM_ADDR_XY_CMP: xy_cmp_reg <= reg_wdata[XYW-1:0];
                    `HBM_ADDR_XY_MASK: xy_mask_reg <= reg_wdata[XYW-1:0];
                    `HBM_ADDR_DATA_CMP: data_cmp_reg <= reg_wdata[DW-1:0];
                    `HBM_ADDR_DATA_MASK: data_mask_reg <= reg_wdata[DW-1:0];
                    `HBM_ADDR_COUNT: begin
                        if (reg_wdata[CW-1:0] != {CW{1'b0}}) begin
                            count_cfg_reg <= reg_wdata[CW-1:0];
                        end
                    end
                    `HBM_ADDR_STATUS: hit_sticky_reg <= 1'b0;
                    default: ;
                endcase
            end
            // Break decision
            if (cfg_write) begin
                pend_after_reg <= 1'b0;
            end else if (reached && fetch_mode && !before_opt) begin
                pend_after_reg <= 1'b1;
            end else if (reached) begin
                break_req <= 1'b1;
                break_before <= fetch_mode;
                hit_sticky_reg <= 1'b1;
            end else if (pend_after_reg && insn_exec_done) begin
                pend_after_reg <= 1'b0;
                break_req <= 1'b1;
                hit_sticky_reg <= 1'b1;
            end
        end
    end

    // Read data, one cycle after the strobe
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (clk_en) begin
            // Zero unless a read was strobed
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                // Index picks the source
                case (reg_addr)
                    `HBM_ADDR_CTRL: reg_rdata <= {{(32-`HBM_CTL_WIDTH){1'b0}}, ctrl_reg};
                    `HBM_ADDR_ADDR_CMP: reg_rdata <= addr_cmp_reg;
                    `HBM_ADDR_ADDR_MASK: reg_rdata <= addr_mask_reg;
                    `HBM_ADDR_XY_CMP: reg_rdata <= {16'h0000, xy_cmp_reg};
                    `HBM_ADDR_XY_MASK: reg_rdata <= {16'h0000, xy_mask_reg};
                    `HBM_ADDR_DATA_CMP: reg_rdata <= data_cmp_reg;
                    `HBM_ADDR_DATA_MASK: reg_rdata <= data_mask_reg;
                    `HBM_ADDR_COUNT: reg_rdata <= {20'h00000, count_cfg_reg};
                    `HBM_ADDR_STATUS: reg_rdata <= {13'h0000, occur_reg, 3'h0, pend_after_reg,
                                                   seq_armed, refused_reg, hit_sticky_reg};
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/hbm_defines.vh
// Constants for the hardware break matcher of break channel one
// Functional notes
// - Address condition met only when observed address equals compare address.
// - General address compare watches data access and program fetch cycles.
// - Fetch address compare watches the address only in program fetch cycles.
// - Fetch match breaks before execution if option set, else after execution.
// - With fetch address compare, only the satisfaction count still applies.
// - X and Y bus compare addresses are held and compared as word addresses.
// - Address and data compares have per-bit masks; masked bits always match.
// - Data matches when value and access size both equal: byte, word, longword.
// - Data condition never met during program fetch cycles.
// - X and Y bus data compare values are word-wide quantities.
// - At most one data condition; configurations with more are refused.
// - Direction qualifier restricts match to read cycles or to write cycles.
// - Cycle type is one of execution, DMA, or none meaning all cycles.
// - Satisfaction count combines with any address, data, direction, cycle qualifier.
// - Count occurrences; full condition met when count reaches value 1 to 4095.
// - When break conditions are satisfied, program execution is halted.
// - Sequential mode: channel two condition first, then channel one, breaks.
// - Observed data bus is 32 bits; byte and word compares pick lanes.
`ifndef HBM_DEFINES_VH
`define HBM_DEFINES_VH

// Register offsets
`define HBM_ADDR_CTRL 4'h0
`define HBM_ADDR_ADDR_CMP 4'h1
`define HBM_ADDR_ADDR_MASK 4'h2
`define HBM_ADDR_XY_CMP 4'h3
`define HBM_ADDR_XY_MASK 4'h4
`define HBM_ADDR_DATA_CMP 4'h5
`define HBM_ADDR_DATA_MASK 4'h6
`define HBM_ADDR_COUNT 4'h7
`define HBM_ADDR_STATUS 4'h8

// Control register fields
`define HBM_CTL_ENABLE 0
`define HBM_CTL_ASEL_LO 1
`define HBM_CTL_ASEL_HI 3
`define HBM_CTL_BEFORE 4
`define HBM_CTL_DSEL_LO 5
`define HBM_CTL_DSEL_HI 10
`define HBM_CTL_DIR_LO 11
`define HBM_CTL_DIR_HI 12
`define HBM_CTL_CTYP_LO 13
`define HBM_CTL_CTYP_HI 14
`define HBM_CTL_SEQ 15
`define HBM_CTL_WIDTH 16

// Address select codes
`define HBM_ASEL_NONE 3'h0
`define HBM_ASEL_GEN 3'h1
`define HBM_ASEL_FETCH 3'h2
`define HBM_ASEL_X 3'h3
`define HBM_ASEL_Y 3'h4

// Data select one-hot bits: byte, word, long, x, y, spare
`define HBM_DSEL_BYTE 0
`define HBM_DSEL_WORD 1
`define HBM_DSEL_LONG 2
`define HBM_DSEL_X 3
`define HBM_DSEL_Y 4

// Direction codes
`define HBM_DIR_ANY 2'h0
`define HBM_DIR_READ 2'h1
`define HBM_DIR_WRITE 2'h2

// Cycle type codes
`define HBM_CTYP_ALL 2'h0
`define HBM_CTYP_EXEC 2'h1
`define HBM_CTYP_DMA 2'h2

// Access size codes on the core bus
`define HBM_SIZE_BYTE 2'h0
`define HBM_SIZE_WORD 2'h1
`define HBM_SIZE_LONG 2'h2

// Count range and reset values
`define HBM_COUNT_MIN 12'h001
`define HBM_COUNT_RESET 12'h001
`define HBM_CTRL_RESET 16'h0000

`endif

// >>> verilog/hbm_masked_cmp.v
// Masked equality comparator used for address and data compares
`timescale 1ns/10ps
`default_nettype none
module hbm_masked_cmp #(
    parameter WIDTH = 32
) (
    // Operands
    input wire [WIDTH-1:0] value,
    input wire [WIDTH-1:0] compare,
    input wire [WIDTH-1:0] mask,
    // Result
    output wire match
);
    // Set mask bits always match
    assign match = &((~(value ^ compare)) | mask);
endmodule
`default_nettype wire

// >>> verilog/hbm_seq_tracker.v
// Sequential break tracker: channel two must precede channel one
`timescale 1ns/10ps
`default_nettype none
module hbm_seq_tracker (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    // Control
    input wire clear,
    input wire ch2_hit,
    // State
    output reg armed_reg
);
    // Arm on channel two hit, drop on clear
    always @(posedge sys_clk) begin
        if (rst) begin
            armed_reg <= 1'b0;
        end else if (clk_en) begin
            if (ch2_hit) begin
                armed_reg <= 1'b1;
            end else if (clear) begin
                armed_reg <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/hbm_break_matcher_sva.sv
// Checker for the break matcher outputs
`timescale 1ns/10ps
`default_nettype none
module hbm_break_matcher_sva #(
    parameter AW = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Core bus
    input wire logic bus_valid,
    input wire logic [AW-1:0] bus_addr,
    input wire logic bus_fetch,
    input wire logic insn_exec_done,
    input wire logic x_valid,
    input wire logic y_valid,
    // Break outputs
    input wire logic break_req,
    input wire logic break_before
);
    logic [15:0] ctrl_reg;
    logic [AW-1:0] acmp_reg;
    logic [AW-1:0] amask_reg;
    logic [11:0] cnt_reg;
    logic ref_reg;
    logic amatch;
    // Shadow of the configuration as software wrote it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg <= 16'h0000;
            acmp_reg <= '0;
            amask_reg <= '0;
            cnt_reg <= 12'h001;
            ref_reg <= 1'b0;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == 4'h0 && $countones(reg_wdata[10:5]) > 1)
                ref_reg <= 1'b1;
            else if (reg_addr == 4'h0)
                ctrl_reg <= reg_wdata[15:0];
            if (reg_addr == 4'h1)
                acmp_reg <= reg_wdata[AW-1:0];
            if (reg_addr == 4'h2)
                amask_reg <= reg_wdata[AW-1:0];
            if (reg_addr == 4'h7 && reg_wdata[11:0] != 12'h000)
                cnt_reg <= reg_wdata[11:0];
        end
    end
    // Masked address equality
    assign amatch = ((bus_addr ^ acmp_reg) & ~amask_reg) == '0;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_cfg_gen;
        ctrl_reg == 16'h0003 && cnt_reg == 12'h001 && !ref_reg;
    endsequence
    sequence s_addr_hit;
        clk_en && bus_valid && amatch && !reg_wr;
    endsequence
    sequence s_cfg_before;
        ctrl_reg[4:0] == 5'h15 && !ctrl_reg[15] && cnt_reg == 12'h001 && !ref_reg;
    endsequence
    a_general_hit: assert property (s_cfg_gen ##0 s_addr_hit |=> break_req)
        else $error("general address hit gave no break");
    a_addr_miss: assert property (ctrl_reg == 16'h0003 && !ref_reg && !(bus_valid && amatch)
        && !insn_exec_done |=> !break_req) else $error("break without address hit");
    a_fetch_before: assert property (s_cfg_before ##0 (s_addr_hit and bus_fetch)
        |=> break_req && break_before) else $error("fetch break before execution missing");
    a_before_pair: assert property (break_before |-> break_req)
        else $error("before flag without break");
    a_no_cause: assert property (break_req |-> $past(bus_valid || insn_exec_done || x_valid || y_valid))
        else $error("break with no bus cycle behind it");
    a_count_read: assert property (reg_rd && reg_addr == 4'h7 |=> reg_rdata == {20'h0, $past(cnt_reg)})
        else $error("count register read wrong");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> !break_req && reg_rdata == 32'h0)
        else $error("outputs active in reset");
endmodule
bind hbm_break_matcher hbm_break_matcher_sva #(.AW(AW)) i_sva (.sys_clk, .rst, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .bus_valid, .bus_addr, .bus_fetch, .insn_exec_done, .x_valid, .y_valid,
    .break_req, .break_before);
`default_nettype wire

// >>> tb/hbm_core_model.sv
// Core bus model: issues single bus cycles, scrambles released address and data lines
`timescale 1ns/10ps
`default_nettype none
module hbm_core_model (
    // Clock
    input wire logic sys_clk,
    // Main bus
    output logic bus_valid = 1'b0,
    output logic [31:0] bus_addr = 32'h0,
    output logic [31:0] bus_data = 32'h0,
    output logic [1:0] bus_size = 2'h0,
    output logic bus_write = 1'b0,
    output logic bus_fetch = 1'b0,
    output logic bus_dma = 1'b0,
    // X and Y buses
    output logic x_valid = 1'b0,
    output logic [15:0] x_addr = 16'h0,
    output logic [15:0] x_data = 16'h0,
    output logic x_write = 1'b0,
    output logic y_valid = 1'b0,
    output logic [15:0] y_addr = 16'h0,
    output logic [15:0] y_data = 16'h0,
    output logic y_write = 1'b0
);
    // One main bus cycle, then released address and data lines carry inverted values
    task automatic cyc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] s, input logic w,
        input logic f, input logic m);
        @(posedge sys_clk);
        bus_valid <= 1'b1;
        bus_addr <= a;
        bus_data <= d;
        bus_size <= s;
        bus_write <= w;
        bus_fetch <= f;
        bus_dma <= m;
        @(posedge sys_clk);
        bus_valid <= 1'b0;
        bus_addr <= ~a;
        bus_data <= ~d;
    endtask
    // One X or Y bus cycle
    task automatic xy(input logic usey, input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        x_valid <= !usey;
        y_valid <= usey;
        x_addr <= a;
        y_addr <= a;
        x_data <= d;
        y_data <= d;
        @(posedge sys_clk);
        x_valid <= 1'b0;
        y_valid <= 1'b0;
        x_addr <= ~a;
        y_addr <= ~a;
        x_data <= ~d;
        y_data <= ~d;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb_hbm_break_matcher.sv
// Self-checking testbench for the break matcher
`include "hbm_defines.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t got %0h want %0h", $time, g, e); end end
module tb_hbm_break_matcher;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic insn_exec_done = 1'b0;
    logic ch2_hit = 1'b0;
    wire [31:0] reg_rdata, bus_addr, bus_data;
    wire [1:0] bus_size;
    wire bus_valid, bus_write, bus_fetch, bus_dma, x_valid, x_write, y_valid, y_write, break_req, break_before;
    wire [15:0] x_addr, x_data, y_addr, y_data;
    int bad_count = 0;
    int tests_run = 0;
    int brk = 0;
    int bef = 0;
    logic [31:0] v;
    logic [15:0] tc [0:7] = '{16'h1003, 16'h1003, 16'h4003, 16'h4003, 16'h2003, 16'h2003, 16'h0803, 16'h0803};
    logic [7:0] tw = 8'b10000010;
    logic [7:0] tm = 8'b00011000;
    logic [7:0] te = 8'b01101010;
    hbm_core_model i_core (.sys_clk(sys_clk), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data),
        .bus_size(bus_size), .bus_write(bus_write), .bus_fetch(bus_fetch), .bus_dma(bus_dma), .x_valid(x_valid),
        .x_addr(x_addr), .x_data(x_data), .x_write(x_write), .y_valid(y_valid), .y_addr(y_addr), .y_data(y_data),
        .y_write(y_write));
    hbm_break_matcher i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_valid(bus_valid),
        .bus_addr(bus_addr), .bus_data(bus_data), .bus_size(bus_size), .bus_write(bus_write),
        .bus_fetch(bus_fetch), .bus_dma(bus_dma), .insn_exec_done(insn_exec_done), .x_valid(x_valid),
        .x_addr(x_addr), .x_data(x_data), .x_write(x_write), .y_valid(y_valid), .y_addr(y_addr),
        .y_data(y_data), .y_write(y_write), .ch2_hit(ch2_hit), .break_req(break_req),
        .break_before(break_before));
    // Clock
    always #5 sys_clk = ~sys_clk;
    // Count break pulses and before-execution flags
    always @(posedge sys_clk) begin
        if (break_req === 1'b1)
            brk++;
        if (break_before === 1'b1)
            bef++;
    end
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Compare break and before counts since the last check
    task chkb(input int n, input int b);
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK(brk, n)
        `CHK(bef, b)
        brk = 0;
        bef = 0;
    endtask
    task pulse(input logic ch2);
        @(posedge sys_clk);
        if (ch2)
            ch2_hit <= 1'b1;
        else
            insn_exec_done <= 1'b1;
        @(posedge sys_clk);
        ch2_hit <= 1'b0;
        insn_exec_done <= 1'b0;
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #100000;
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        close_out;
    end
    // Test sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`HBM_ADDR_COUNT, v);
        `CHK(v, 32'h1)
        rd(4'h9, v);
        `CHK(v, 32'h0)
        $display("test reset done");
        wr(`HBM_ADDR_ADDR_CMP, 32'h1000);
        wr(`HBM_ADDR_CTRL, 32'h0003);
        i_core.cyc(32'h1000, 32'h0, `HBM_SIZE_LONG, 1'b0, 1'b0, 1'b0);
        chkb(1, 0);
        i_core.cyc(32'h1004, 32'h0, `HBM_SIZE_LONG, 1'b0, 1'b0, 1'b0);
        chkb(0, 0);
        i_core.cyc(32'h1000, 32'h0, `HBM_SIZE_LONG, 1'b0, 1'b1, 1'b0);
        chkb(1, 0);
        wr(`HBM_ADDR_ADDR_MASK, 32'hf);
        i_core.cyc(32'h100c, 32'h0, `HBM_SIZE_LONG, 1'b0, 1'b0, 1'b0);
        chkb(1, 0);
        wr(`HBM_ADDR_ADDR_MASK, 32'h0);
        $display("test address done");
        wr(`HBM_ADDR_CTRL, 32'h5015);
        i_core.cyc(32'h1000, 32'h0, `HBM_SIZE_WORD, 1'b0, 1'b1, 1'b0);
        chkb(1, 1);
        i_core.cyc(32'h1000, 32'h0, `HBM_SIZE_WORD, 1'b1, 1'b0, 1'b1);
        chkb(0, 0);
        wr(`HBM_ADDR_CTRL, 32'h0005);
        i_core.cyc(32'h1000, 32'h0, `HBM_SIZE_WORD, 1'b0, 1'b1, 1'b0);
        chkb(0, 0);
        pulse(1'b0);
        chkb(1, 0);
        $display("test fetch done");
        wr(`HBM_ADDR_ADDR_CMP, 32'h1001);
        wr(`HBM_ADDR_DATA_CMP, 32'h5a);
        wr(`HBM_ADDR_CTRL, 32'h0023);
        i_core.cyc(32'h1001, 32'h005a0000, `HBM_SIZE_BYTE, 1'b0, 1'b0, 1'b0);
        chkb(1, 0);
        i_core.cyc(32'h1001, 32'h0000005a, `HBM_SIZE_BYTE, 1'b0, 1'b0, 1'b0);
        chkb(0, 0);
        i_core.cyc(32'h1001, 32'h005a0000, `HBM_SIZE_WORD, 1'b0, 1'b0, 1'b0);
        chkb(0, 0);
        i_core.cyc(32'h1001, 32'h005a0000, `HBM_SIZE_BYTE, 1'b0, 1'b1, 1'b0);
        chkb(0, 0);
        $display("test data done");
        for (int i = 0; i < 8; i++) begin
            wr(`HBM_ADDR_CTRL, {16'h0, tc[i]});
            i_core.cyc(32'h1001, 32'h0, `HBM_SIZE_BYTE, tw[i], 1'b0, tm[i]);
            chkb(te[i], 0);
        end
        $display("test qualifiers done");
        wr(`HBM_ADDR_COUNT, 32'h3);
        wr(`HBM_ADDR_CTRL, 32'h0003);
        repeat (2) i_core.cyc(32'h1001, 32'h0, `HBM_SIZE_BYTE, 1'b0, 1'b0, 1'b0);
        wr(`HBM_ADDR_CTRL, 32'h0003);
        repeat (2) i_core.cyc(32'h1001, 32'h0, `HBM_SIZE_BYTE, 1'b0, 1'b0, 1'b0);
        chkb(0, 0);
        i_core.cyc(32'h1001, 32'h0, `HBM_SIZE_BYTE, 1'b0, 1'b0, 1'b0);
        chkb(1, 0);
        wr(`HBM_ADDR_COUNT, 32'h0);
        rd(`HBM_ADDR_COUNT, v);
        `CHK(v, 32'h3)
        wr(`HBM_ADDR_COUNT, 32'h1);
        clk_en <= 1'b0;
        i_core.cyc(32'h1001, 32'h0, `HBM_SIZE_BYTE, 1'b0, 1'b0, 1'b0);
        clk_en <= 1'b1;
        chkb(0, 0);
        $display("test count done");
        wr(`HBM_ADDR_XY_CMP, 32'h0123);
        wr(`HBM_ADDR_CTRL, 32'h0007);
        i_core.xy(1'b0, 16'h0123, 16'h0);
        chkb(1, 0);
        i_core.xy(1'b1, 16'h0123, 16'h0);
        chkb(0, 0);
        wr(`HBM_ADDR_CTRL, 32'h0009);
        i_core.xy(1'b1, 16'h0123, 16'h0);
        chkb(1, 0);
        wr(`HBM_ADDR_DATA_CMP, 32'h0abc);
        wr(`HBM_ADDR_CTRL, 32'h0101);
        i_core.xy(1'b0, 16'h0456, 16'h0abc);
        chkb(1, 0);
        $display("test xy done");
        wr(`HBM_ADDR_CTRL, 32'h8003);
        i_core.cyc(32'h1001, 32'h0, `HBM_SIZE_BYTE, 1'b0, 1'b0, 1'b0);
        chkb(0, 0);
        pulse(1'b1);
        i_core.cyc(32'h1001, 32'h0, `HBM_SIZE_BYTE, 1'b0, 1'b0, 1'b0);
        chkb(1, 0);
        wr(`HBM_ADDR_CTRL, 32'h0063);
        rd(`HBM_ADDR_STATUS, v);
        `CHK(v[1:0], 2'h3)
        rd(`HBM_ADDR_CTRL, v);
        `CHK(v, 32'h8003)
        $display("test sequence done");
        close_out;
    end
endmodule
`default_nettype wire
